/* logic/mid_decoder.sv */
// Multifunction input decoder: five terminals to drive commands, APB slave.
// Assumes terminals are asynchronous pins and the drive supplies run state and output frequency.
// What this block does
// [RULE1] Three preset terminals form speed index bits
// [RULE2] Index selects its frequency and ramp pair
// [RULE3] Jog forward, jog reverse, both means stop
// [RULE4] Up terminal raises command to upper limit
// [RULE5] Down terminal lowers command to zero
// [RULE6] Short press changes exactly one step
// [RULE7] Function ten selects second ramp times
// [RULE8] Function eleven holds present output frequency
// [RULE9] Function twelve selects alternative run source
// [RULE10] Function thirteen selects alternative frequency source
// [RULE11] Function fourteen requests controlled deceleration stop
// [RULE12] Function fifteen blocks output, motor coasts
// [RULE13] Function sixteen disables PID while active
// [RULE14] Function seventeen clears resettable faults
// [RULE15] Function eighteen enables automatic run sequencer
// [RULE16] Policy zero holds frequency, stepping off stopped
// [RULE17] Policy one returns frequency to zero
// [RULE18] Policy two holds frequency, stepping stays on
// [RULE19] Policies zero, two copy output to panel
// [RULE20] States accepted after configured scan periods
// [RULE21] Scan period unit is one millisecond
// [RULE22] Per-terminal polarity bit, bit zero first
// [RULE23] Polarity before debounce, tick from clock
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
module mid_decoder
	import mid_pkg::*;
#(
	parameter int TICK_CYCLES = MID_TICK_CYC,
	parameter int HOLD_MS     = MID_HOLD_MS,
	parameter int REPEAT_MS   = MID_REPEAT_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [4:0]  multifunction_inputs,
	input  wire logic        run_active,
	input  wire logic [15:0] out_freq,
	output mid_cmd_t         cmd,
	output logic      [15:0] panel_freq
);
	// All state of the block sits in one struct.
	// Reset loads it with constants, and the registering process copies the next value.
	// No register is updated anywhere else, so every field has a single driver.
	typedef struct packed {
		logic [4:0]      s1;
		logic [4:0]      s2;
		logic [4:0]      stab;
		logic [4:0][7:0] cnt;
		logic [15:0]     tick_cnt;
		logic            tick;
		logic [15:0]     hold_ms;
		logic [15:0]     rep_ms;
		mid_ud_t         ud_st;
		logic            run_q;
		logic            rst_fn_q;
		logic [15:0]     udf;
		logic [15:0]     panel;
		logic [15:0]     limit;
		logic [8:0]      step;
		logic [4:0]      pol;
		logic [1:0]      policy;
		logic [7:0]      scan;
		logic [4:0][4:0] fn;
		logic [31:0]     rdata;
		logic            slverr;
		mid_cmd_t        cmd;
	} mid_state_t;

	// The timers compare against their last count, so each period spans exactly N ticks.
	// The parameters must stay below 65536, the width of the counters.
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	localparam logic [15:0] HOLD_LAST = 16'(HOLD_MS - 1);
	localparam logic [15:0] REP_LAST  = 16'(REPEAT_MS - 1);

	mid_state_t st_r;
	mid_state_t st_nxt;

	// Returns one when any accepted terminal carries the given function.
	// Several terminals may share one function; their states are then ORed.
	// A terminal with an unused code simply matches no function.
	function automatic logic fn_on(input logic [4:0][4:0] fn,
			input logic [4:0] act, input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < MID_NTERM; i++) begin
			if (fn[i] == code && act[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Applies one up or down step with clamping at the limit or at zero.
	// The sum is one bit wider so a step near the top cannot wrap past the limit.
	// The difference is checked first so a large step cannot wrap below zero.
	function automatic logic [15:0] ud_apply(input logic [15:0] f,
			input logic [8:0] stp, input logic [15:0] lim, input logic up);
		logic [16:0] sum;
		sum = 17'(f) + 17'(stp);
		if (up) begin
			ud_apply = (sum > 17'(lim)) ? lim : sum[15:0];
		end else begin
			ud_apply = (f < 16'(stp)) ? 16'h0000 : 16'(f - 16'(stp));
		end
	endfunction

	// Returns one for register offsets that exist.
	// Every other offset, unaligned ones included, is refused with an error.
	function automatic logic addr_ok(input logic [7:0] a);
		return a == MID_OFS_CFG || a == MID_OFS_FUNC || a == MID_OFS_STEP
			|| a == MID_OFS_PANEL || a == MID_OFS_STAT || a == MID_OFS_UDF;
	endfunction

	always_comb begin
		logic [4:0]  corr;
		logic [7:0]  scan_eff;
		logic        up;
		logic        dn;
		logic        dir_up;
		logic        moving;
		logic        ud_en;
		logic        do_step;
		logic        run_fall;
		logic        rst_fn;
		logic        wr;
		logic [31:0] stat;
		corr = 5'h00;
		scan_eff = 8'h00;
		up = 1'b0;
		dn = 1'b0;
		dir_up = 1'b0;
		moving = 1'b0;
		ud_en = 1'b0;
		do_step = 1'b0;
		run_fall = 1'b0;
		rst_fn = 1'b0;
		wr = 1'b0;
		stat = 32'h0000_0000;
		st_nxt = st_r;

		// Two-stage synchroniser on the terminal pins.
		// The pins are asynchronous, so only the second stage is read by the decode.
		// A metastable first stage therefore never reaches the debounce counters.
		st_nxt.s1 = multifunction_inputs;
		st_nxt.s2 = st_r.s1;

		// One millisecond tick from the system clock. [RULE21] [RULE23]
		// The debounce, hold and repeat timers all count this tick.
		// Every timing figure of the block therefore scales with the tick parameter.
		st_nxt.tick = 1'b0;
		if (st_r.tick_cnt >= TICK_LAST) begin
			st_nxt.tick_cnt = 16'h0000;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
		end

		// Polarity correction, then a persistence counter per terminal.
		// A normally closed contact is inverted first, so all later logic is active high.
		// A scan count of zero is treated as one, the shortest legal setting.
		// The counter restarts whenever the input agrees with the accepted state again.
		corr = st_r.s2 ^ st_r.pol; // [RULE22] [RULE23]
		scan_eff = (st_r.scan == 8'h00) ? 8'h01 : st_r.scan;
		for (int i = 0; i < MID_NTERM; i++) begin
			if (corr[i] == st_r.stab[i]) begin
				st_nxt.cnt[i] = 8'h00; // [RULE20]
			end else if (st_r.tick) begin
				if (st_r.cnt[i] + 8'h01 >= scan_eff) begin
					st_nxt.stab[i] = corr[i]; // [RULE20]
					st_nxt.cnt[i] = 8'h00;
				end else begin
					st_nxt.cnt[i] = st_r.cnt[i] + 8'h01;
				end
			end
		end

		// Level commands decoded from the accepted terminal states.
		// Each command follows its terminal one cycle after the state is accepted.
		// Changing a function code takes effect on the next cycle, without debounce.
		st_nxt.cmd.speed_idx = {fn_on(st_r.fn, st_r.stab, MID_FN_PS_MSB),
			fn_on(st_r.fn, st_r.stab, MID_FN_PS_MID),
			fn_on(st_r.fn, st_r.stab, MID_FN_PS_LSB)}; // [RULE1] [RULE2]
		st_nxt.cmd.jog_fwd = fn_on(st_r.fn, st_r.stab, MID_FN_JOG_FWD)
			& ~fn_on(st_r.fn, st_r.stab, MID_FN_JOG_REV); // [RULE3]
		st_nxt.cmd.jog_rev = fn_on(st_r.fn, st_r.stab, MID_FN_JOG_REV)
			& ~fn_on(st_r.fn, st_r.stab, MID_FN_JOG_FWD); // [RULE3]
		st_nxt.cmd.jog_stop = fn_on(st_r.fn, st_r.stab, MID_FN_JOG_FWD)
			& fn_on(st_r.fn, st_r.stab, MID_FN_JOG_REV); // [RULE3]
		st_nxt.cmd.acc_sel2 = fn_on(st_r.fn, st_r.stab, MID_FN_ACC2); // [RULE7]
		st_nxt.cmd.ramp_hold = fn_on(st_r.fn, st_r.stab, MID_FN_HOLD); // [RULE8]
		st_nxt.cmd.run_src_alt = fn_on(st_r.fn, st_r.stab, MID_FN_RUN_ALT); // [RULE9]
		st_nxt.cmd.frq_src_alt = fn_on(st_r.fn, st_r.stab, MID_FN_FRQ_ALT); // [RULE10]
		st_nxt.cmd.rapid_stop = fn_on(st_r.fn, st_r.stab, MID_FN_RAPID); // [RULE11]
		st_nxt.cmd.output_block = fn_on(st_r.fn, st_r.stab, MID_FN_BLOCK); // [RULE12]
		st_nxt.cmd.pid_disable = fn_on(st_r.fn, st_r.stab, MID_FN_PID_OFF); // [RULE13]
		st_nxt.cmd.auto_seq_en = fn_on(st_r.fn, st_r.stab, MID_FN_AUTO); // [RULE15]

		// Fault reset is a single pulse on activation of the reset terminal.
		// Holding the terminal on does not repeat the reset.
		// The terminal must be released and pressed again for another pulse.
		rst_fn = fn_on(st_r.fn, st_r.stab, MID_FN_RESET);
		st_nxt.rst_fn_q = rst_fn;
		st_nxt.cmd.fault_reset = rst_fn & ~st_r.rst_fn_q; // [RULE14]

		// Up/down is blocked while stopped only under the hold-and-disable policy.
		// Both terminals on at once cancel out, and the command does not move.
		// Under that policy the panel setting is the only way to change frequency.
		ud_en = st_r.run_q | (st_r.policy != MID_POL_HOLD_DIS); // [RULE16] [RULE18]
		st_nxt.cmd.updown_en = ud_en;
		up = fn_on(st_r.fn, st_r.stab, MID_FN_UP);
		dn = fn_on(st_r.fn, st_r.stab, MID_FN_DOWN);
		moving = (up ^ dn) & ud_en;
		dir_up = up;

		// Up/down sequencer: one step per press, repeat after the hold time.
		// A press shorter than the hold time therefore gives exactly one step.
		// Release returns to idle at once, so the next press starts a fresh hold.
		// Stepping stops at the upper limit or at zero and never wraps.
		case (st_r.ud_st)
			MID_UD_IDLE: begin
				if (moving) begin
					do_step = 1'b1; // [RULE6]
					st_nxt.hold_ms = 16'h0000;
					st_nxt.ud_st = MID_UD_WAIT;
				end
			end
			MID_UD_WAIT: begin
				if (!moving) begin
					st_nxt.ud_st = MID_UD_IDLE; // [RULE6]
				end else if (st_r.tick) begin
					if (st_r.hold_ms >= HOLD_LAST) begin
						st_nxt.rep_ms = 16'h0000;
						st_nxt.ud_st = MID_UD_REPEAT;
					end else begin
						st_nxt.hold_ms = st_r.hold_ms + 16'h0001;
					end
				end
			end
			MID_UD_REPEAT: begin
				if (!moving) begin
					st_nxt.ud_st = MID_UD_IDLE;
				end else if (st_r.tick) begin
					if (st_r.rep_ms >= REP_LAST) begin
						do_step = 1'b1; // [RULE4] [RULE5]
						st_nxt.rep_ms = 16'h0000;
					end else begin
						st_nxt.rep_ms = st_r.rep_ms + 16'h0001;
					end
				end
			end
			default: begin
				st_nxt.ud_st = MID_UD_IDLE;
			end
		endcase
		if (do_step) begin
			st_nxt.udf = ud_apply(st_r.udf, st_r.step, st_r.limit, dir_up); // [RULE4] [RULE5]
		end

		// Stop handling on the falling edge of the run signal.
		// The run input shares this clock, so it is compared with its registered copy.
		// The zero policy comes after the step logic, so it wins over a step.
		// A step that lands in the same cycle as the stop is therefore discarded.
		st_nxt.run_q = run_active;
		run_fall = st_r.run_q & ~run_active;
		if (run_fall && st_r.policy == MID_POL_ZERO) begin
			st_nxt.udf = 16'h0000; // [RULE17]
			st_nxt.ud_st = MID_UD_IDLE;
		end
		st_nxt.cmd.updown_freq = st_nxt.udf;

		// Status word for software.
		stat[4:0] = st_r.stab;
		stat[10:8] = st_r.cmd.speed_idx;
		stat[16] = st_r.cmd.jog_fwd;
		stat[17] = st_r.cmd.jog_rev;
		stat[18] = st_r.cmd.jog_stop;
		stat[19] = st_r.cmd.acc_sel2;
		stat[20] = st_r.cmd.ramp_hold;
		stat[21] = st_r.cmd.run_src_alt;
		stat[22] = st_r.cmd.frq_src_alt;
		stat[23] = st_r.cmd.rapid_stop;
		stat[24] = st_r.cmd.output_block;
		stat[25] = st_r.cmd.pid_disable;
		stat[26] = st_r.cmd.auto_seq_en;
		stat[27] = st_r.run_q;
		stat[28] = st_r.cmd.updown_en;

		// APB setup phase: read data and error are captured for the access phase.
		// The slave answers with no wait states, so pready is tied high.
		// The captured word stands unchanged until the next setup cycle.
		if (psel && !penable) begin
			st_nxt.slverr = !addr_ok(paddr)
				|| (pwrite && (paddr == MID_OFS_STAT || paddr == MID_OFS_UDF));
			st_nxt.rdata = 32'h0000_0000;
			case (paddr)
				MID_OFS_CFG: begin
					st_nxt.rdata[MID_CFG_POL_LSB +: 5] = st_r.pol;
					st_nxt.rdata[MID_CFG_POLICY_LSB +: 2] = st_r.policy;
					st_nxt.rdata[MID_CFG_SCAN_LSB +: 8] = st_r.scan;
				end
				MID_OFS_FUNC: st_nxt.rdata[24:0] = st_r.fn;
				MID_OFS_STEP: begin
					st_nxt.rdata[MID_STEP_LSB +: 9] = st_r.step;
					st_nxt.rdata[MID_LIMIT_LSB +: 16] = st_r.limit;
				end
				MID_OFS_PANEL: st_nxt.rdata[15:0] = st_r.panel;
				MID_OFS_STAT: st_nxt.rdata = stat;
				MID_OFS_UDF: st_nxt.rdata[15:0] = st_r.udf;
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// APB access phase: writes land at the completing edge.
		// A refused access leaves every register untouched.
		wr = psel & penable & pwrite & ~st_r.slverr;
		if (wr) begin
			case (paddr)
				MID_OFS_CFG: begin
					st_nxt.pol = pwdata[MID_CFG_POL_LSB +: 5];
					st_nxt.policy = pwdata[MID_CFG_POLICY_LSB +: 2];
					st_nxt.scan = pwdata[MID_CFG_SCAN_LSB +: 8];
				end
				MID_OFS_FUNC: st_nxt.fn = pwdata[24:0];
				MID_OFS_STEP: begin
					st_nxt.step = pwdata[MID_STEP_LSB +: 9];
					st_nxt.limit = pwdata[MID_LIMIT_LSB +: 16];
				end
				MID_OFS_PANEL: st_nxt.panel = pwdata[15:0];
				default: st_nxt.panel = st_nxt.panel;
			endcase
		end

		// A stop under any policy but one, the zero policy, copies output frequency into the panel setting; it wins over a write.
		if (run_fall && st_r.policy != MID_POL_ZERO) begin
			st_nxt.panel = out_freq; // [RULE19] [RULE16] [RULE18]
		end
	end

	// Registers the whole state.
	// Reset values are constants only, so the asynchronous branch stays clean.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.ud_st <= MID_UD_IDLE;
			st_r.limit <= MID_RST_LIMIT;
			st_r.panel <= MID_RST_PANEL;
			st_r.step <= MID_RST_STEP;
			st_r.pol <= MID_RST_POL;
			st_r.policy <= MID_RST_POLICY;
			st_r.scan <= MID_RST_SCAN;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Output assignments.
	// Data outputs come straight from registers; only pready and pslverr are combinational.
	// The error flag is masked to the access phase so it never shows in setup.
	assign prdata = st_r.rdata;
	assign pslverr = psel & penable & st_r.slverr;
	assign pready = 1'b1;
	assign cmd = st_r.cmd;
	assign panel_freq = st_r.panel;
endmodule

/* pkg/mid_pkg.sv */
// Constants and types of the multifunction input decoder.
// Assumes a single 25 MHz clock and an APB register port.
package mid_pkg;
	localparam int MID_NTERM = 5;
	localparam int MID_CLK_NS = 40;
	localparam int MID_TICK_NS = 1000000;
	localparam int MID_TICK_CYC = (MID_TICK_NS + MID_CLK_NS - 1) / MID_CLK_NS;
	localparam int MID_HOLD_MS = 2000;
	localparam int MID_REPEAT_MS = 100;
	// Register byte offsets.
	localparam logic [7:0] MID_OFS_CFG = 8'h00;
	localparam logic [7:0] MID_OFS_FUNC = 8'h04;
	localparam logic [7:0] MID_OFS_STEP = 8'h08;
	localparam logic [7:0] MID_OFS_PANEL = 8'h0c;
	localparam logic [7:0] MID_OFS_STAT = 8'h10;
	localparam logic [7:0] MID_OFS_UDF = 8'h14;
	// Field positions.
	localparam int MID_CFG_POL_LSB = 0;
	localparam int MID_CFG_POLICY_LSB = 8;
	localparam int MID_CFG_SCAN_LSB = 16;
	localparam int MID_STEP_LSB = 0;
	localparam int MID_LIMIT_LSB = 16;
	// Reset values.
	localparam logic [4:0] MID_RST_POL = 5'h00;
	localparam logic [1:0] MID_RST_POLICY = 2'h0;
	localparam logic [7:0] MID_RST_SCAN = 8'h01;
	localparam logic [8:0] MID_RST_STEP = 9'h000;
	localparam logic [15:0] MID_RST_LIMIT = 16'h1770;
	localparam logic [15:0] MID_RST_PANEL = 16'h0000;
	// Terminal function codes.
	localparam logic [4:0] MID_FN_PS_MSB = 5'h02;
	localparam logic [4:0] MID_FN_PS_MID = 5'h03;
	localparam logic [4:0] MID_FN_PS_LSB = 5'h04;
	localparam logic [4:0] MID_FN_JOG_FWD = 5'h06;
	localparam logic [4:0] MID_FN_JOG_REV = 5'h07;
	localparam logic [4:0] MID_FN_UP = 5'h08;
	localparam logic [4:0] MID_FN_DOWN = 5'h09;
	localparam logic [4:0] MID_FN_ACC2 = 5'h0a;
	localparam logic [4:0] MID_FN_HOLD = 5'h0b;
	localparam logic [4:0] MID_FN_RUN_ALT = 5'h0c;
	localparam logic [4:0] MID_FN_FRQ_ALT = 5'h0d;
	localparam logic [4:0] MID_FN_RAPID = 5'h0e;
	localparam logic [4:0] MID_FN_BLOCK = 5'h0f;
	localparam logic [4:0] MID_FN_PID_OFF = 5'h10;
	localparam logic [4:0] MID_FN_RESET = 5'h11;
	localparam logic [4:0] MID_FN_AUTO = 5'h12;
	// Post-stop policies.
	localparam logic [1:0] MID_POL_HOLD_DIS = 2'h0;
	localparam logic [1:0] MID_POL_ZERO = 2'h1;
	localparam logic [1:0] MID_POL_HOLD_EN = 2'h2;
	typedef enum logic [1:0] {
		MID_UD_IDLE = 2'b00,
		MID_UD_WAIT = 2'b01,
		MID_UD_REPEAT = 2'b11
	} mid_ud_t;
	// Decoded drive commands.
	typedef struct packed {
		logic [2:0] speed_idx;
		logic jog_fwd;
		logic jog_rev;
		logic jog_stop;
		logic acc_sel2;
		logic ramp_hold;
		logic run_src_alt;
		logic frq_src_alt;
		logic rapid_stop;
		logic output_block;
		logic pid_disable;
		logic fault_reset;
		logic auto_seq_en;
		logic updown_en;
		logic [15:0] updown_freq;
	} mid_cmd_t;
endpackage

/* testbench/mid_decoder_props.sv */
// Checker of the decoder's port behaviour.
// Assumes it is bound to mid_decoder and sees only its ports.
`timescale 1ns/100ps
module mid_decoder_props
	import mid_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [4:0]  multifunction_inputs,
	input wire logic        run_active,
	input wire logic [15:0] out_freq,
	input wire mid_cmd_t    cmd,
	input wire logic [15:0] panel_freq
);
	logic [1:0] pol_r;
	// Shadow of the post-stop policy, taken from register writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_r <= MID_RST_POLICY;
		end else if (psel && penable && pwrite && paddr == MID_OFS_CFG) begin
			pol_r <= pwdata[MID_CFG_POLICY_LSB +: 2];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Run falls from one cycle to the next.
	sequence s_run_fall;
		run_active ##1 !run_active;
	endsequence
	property p_ready;
		psel |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in a transfer");
	property p_err_map;
		psel && penable && paddr > MID_OFS_UDF |-> pslverr && prdata == 32'h0;
	endproperty
	a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
	property p_err_ro;
		psel && penable && pwrite && paddr >= MID_OFS_STAT |-> pslverr;
	endproperty
	a_err_ro: assert property (p_err_ro) else $error("read-only write not refused");
	property p_jog;
		cmd.jog_stop |-> !cmd.jog_fwd && !cmd.jog_rev;
	endproperty
	a_jog: assert property (p_jog) else $error("jog stop with jog run");
	property p_pulse;
		cmd.fault_reset |=> !cmd.fault_reset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("fault reset longer than a cycle");
	property p_one_step;
		$changed(cmd.updown_freq) && cmd.updown_en |=> $stable(cmd.updown_freq);
	endproperty
	a_one_step: assert property (p_one_step) else $error("two steps back to back");
	property p_frozen;
		pol_r == MID_POL_HOLD_DIS && !cmd.updown_en && $past(!cmd.updown_en)
			&& $past(!cmd.updown_en, 2) |-> $stable(cmd.updown_freq);
	endproperty
	a_frozen: assert property (p_frozen) else $error("stepping while disabled");
	property p_panel_cause;
		$changed(panel_freq) |-> $past(psel && penable && pwrite && paddr == MID_OFS_PANEL)
			|| ($past(!run_active) && $past(run_active, 2));
	endproperty
	a_panel_cause: assert property (p_panel_cause) else $error("panel changed uncaused");
	property p_zero_stop;
		s_run_fall ##0 (pol_r == MID_POL_ZERO) |-> ##[1:3] cmd.updown_freq == 16'h0;
	endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("no zero on stop");
	property p_copy_stop;
		s_run_fall ##0 (pol_r != MID_POL_ZERO) |=> panel_freq == $past(out_freq);
	endproperty
	a_copy_stop: assert property (p_copy_stop) else $error("no copy on stop");
endmodule

/* testbench/mid_switch_model.sv */
// External switch bank model driving the five terminals.
// Assumes the bench sets wanted levels and noise just after a clock edge.
`timescale 1ns/100ps
module mid_switch_model (
	input  wire logic       pclk,
	input  wire logic [4:0] level,
	input  wire logic [4:0] noise,
	output logic      [4:0] pins
);
	// Contacts follow the wanted level; noise flips them as a bounce would.
	always_ff @(posedge pclk) begin
		pins <= level ^ noise;
	end
endmodule

/* testbench/mid_decoder_tb.sv */
// Self-checking bench of the decoder over APB and the terminal pins.
// Assumes shortened tick and hold parameters and a switch model on the pins.
`timescale 1ns/100ps
module mid_decoder_tb;
	import mid_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  pins;
	logic [4:0]  lvl = 5'h00;
	logic [4:0]  noise = 5'h00;
	logic        run_active = 1'b0;
	logic [15:0] out_freq = 16'h0;
	mid_cmd_t    cmd;
	logic [15:0] panel_freq;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          fr_cnt = 0;
	logic [31:0] r;
	logic        e;
	logic [4:0]  codes [10] = '{5'h06, 5'h07, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
		5'h10, 5'h12};
	int          bits [10] = '{16, 17, 19, 20, 21, 22, 23, 24, 25, 26};

	mid_decoder #(.TICK_CYCLES(4), .HOLD_MS(5), .REPEAT_MS(2)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.multifunction_inputs(pins), .run_active(run_active), .out_freq(out_freq),
		.cmd(cmd), .panel_freq(panel_freq));
	mid_switch_model u_sw (.pclk(pclk), .level(lvl), .noise(noise), .pins(pins));

	// Clock of 40 ns period.
	always #20 pclk = ~pclk;

	// Counts reset pulses and cuts a hung run short.
	always @(posedge pclk) begin
		cyc++;
		if (cmd.fault_reset === 1'b1)
			fr_cnt++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task tally_and_finish;
		if (bad_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; waits for pready, releases, then lets an idle edge pass.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	task press(input logic [4:0] m, input int n);
		lvl <= m;
		wt(n);
		lvl <= 5'h00;
		wt(20);
	endtask

	// Main sequence.
	initial begin
		wt(5);
		presetn <= 1'b1;
		wt(1);
		rd(MID_OFS_CFG, 32'h00010000);
		rd(MID_OFS_STEP, 32'h17700000);
		rd(MID_OFS_FUNC, 32'h0);
		rd(MID_OFS_PANEL, 32'h0);
		rd(8'h18, 32'h0);
		chk(e, 1'b1);
		wr(MID_OFS_STAT, 32'hffffffff);
		chk(e, 1'b1);
		foreach (codes[i]) begin
			wr(MID_OFS_FUNC, {27'h0, codes[i]});
			lvl <= 5'h01;
			wt(20);
			rd(MID_OFS_STAT, 32'h1 | (32'h1 << bits[i]));
			lvl <= 5'h00;
			wt(20);
		end
		wr(MID_OFS_FUNC, 32'h11);
		press(5'h01, 20);
		chk(fr_cnt, 32'h1);
		wr(MID_OFS_FUNC, 32'h1062);
		for (int i = 0; i < 8; i++) begin
			lvl <= {2'b00, i[0], i[1], i[2]};
			wt(20);
			chk(cmd.speed_idx, i[2:0]);
		end
		wr(MID_OFS_FUNC, 32'he6);
		lvl <= 5'h03;
		wt(20);
		rd(MID_OFS_STAT, 32'h00040003);
		lvl <= 5'h00;
		wr(MID_OFS_FUNC, 32'ha);
		wr(MID_OFS_CFG, 32'h00030001);
		wt(30);
		chk(cmd.acc_sel2, 1'b1);
		noise <= 5'h01;
		wt(6);
		noise <= 5'h00;
		wt(30);
		chk(cmd.acc_sel2, 1'b1);
		lvl <= 5'h01;
		wt(8);
		chk(cmd.acc_sel2, 1'b1);
		wt(30);
		chk(cmd.acc_sel2, 1'b0);
		lvl <= 5'h00;
		wr(MID_OFS_CFG, 32'h00010200);
		wr(MID_OFS_FUNC, 32'h128);
		wr(MID_OFS_STEP, 32'h0019000a);
		run_active <= 1'b1;
		wt(20);
		press(5'h01, 10);
		chk(cmd.updown_freq, 32'd10);
		press(5'h01, 10);
		chk(cmd.updown_freq, 32'd20);
		rd(MID_OFS_UDF, 32'd20);
		press(5'h01, 10);
		chk(cmd.updown_freq, 32'd25);
		press(5'h02, 10);
		chk(cmd.updown_freq, 32'd15);
		press(5'h02, 200);
		chk(cmd.updown_freq, 32'd0);
		out_freq <= 16'h1234;
		run_active <= 1'b0;
		wt(4);
		chk(panel_freq, 32'h1234);
		chk(cmd.updown_en, 1'b1);
		press(5'h01, 10);
		chk(cmd.updown_freq, 32'd10);
		wr(MID_OFS_CFG, 32'h00010000);
		run_active <= 1'b1;
		out_freq <= 16'h0777;
		wt(4);
		run_active <= 1'b0;
		wt(4);
		chk(panel_freq, 32'h0777);
		chk(cmd.updown_en, 1'b0);
		press(5'h01, 10);
		chk(cmd.updown_freq, 32'd10);
		wr(MID_OFS_CFG, 32'h00010100);
		run_active <= 1'b1;
		out_freq <= 16'h0555;
		wt(4);
		run_active <= 1'b0;
		wt(4);
		chk(cmd.updown_freq, 32'd0);
		chk(panel_freq, 32'h0777);
		wr(MID_OFS_PANEL, 32'h0abc);
		rd(MID_OFS_PANEL, 32'h0abc);
		tally_and_finish();
	end
endmodule

bind mid_decoder mid_decoder_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.multifunction_inputs(multifunction_inputs), .run_active(run_active),
	.out_freq(out_freq), .cmd(cmd), .panel_freq(panel_freq));
